// ---- core/dpc_beam_end.sv ----
module dpc_beam_end #(
    parameter int MAX_OFS = dpc_pkg::MAX_OFS_DEF
) (
    // Clock and reset
    input  wire logic                               clock_in,
    input  wire logic                               rst_n_in,
    // Network configuration
    input  wire logic [dpc_pkg::ID_W-1:0]           own_id_in,
    input  wire logic                               diversity_in,
    input  wire logic [$clog2(MAX_OFS+1)-1:0]       frame_offset_in,
    input  wire logic [dpc_pkg::PWR_W-1:0]          step_small_in,
    input  wire logic [dpc_pkg::PWR_W-1:0]          step_large_in,
    input  wire logic signed [dpc_pkg::PWR_W-1:0]   balance_in,
    input  wire logic signed [dpc_pkg::PWR_W-1:0]   data_offset_in,
    input  wire logic [dpc_pkg::SIR_W-1:0]          quality_in,
    input  wire logic [dpc_pkg::SIR_W-1:0]          quality_thr_in,
    // Beam status
    output logic [1:0]                              decoded_cmd_out,
    output logic signed [dpc_pkg::PWR_W-1:0]        ctrl_power_out,
    output logic signed [dpc_pkg::PWR_W-1:0]        data_power_out,
    output logic                                    primary_out,
    // Link from the mobile terminal
    dpc_link_if.beam                                link
);
    localparam int OFS_W = $clog2(MAX_OFS + 1);
    localparam int ACC_W = dpc_pkg::PWR_W + 2;

    generate
        // The decision line needs at least two taps to shift
        if (MAX_OFS < 1 || MAX_OFS > 31) begin : g_bad_ofs
            $error("MAX_OFS must lie between 1 and 31");
        end
    endgenerate

    logic signed [dpc_pkg::PWR_W-1:0] power;
    logic signed [ACC_W-1:0]          step;
    logic signed [ACC_W-1:0]          next_power;
    logic                             decision;
    logic [MAX_OFS:0]                 state_line;
    logic [MAX_OFS:0]                 valid_line;
    logic                             primary;

    // Command to adjustment
    always_comb begin
        case (link.power_cmd)
            dpc_pkg::DPC_DOWN_LARGE: step = -ACC_W'(step_large_in); // R6
            dpc_pkg::DPC_DOWN_SMALL: step = -ACC_W'(step_small_in); // R6
            dpc_pkg::DPC_UP_SMALL:   step =  ACC_W'(step_small_in); // R6
            dpc_pkg::DPC_UP_LARGE:   step =  ACC_W'(step_large_in); // R6
            default:                 step = '0;
        endcase
        next_power = ACC_W'(power) + step + ACC_W'(balance_in); // R5
        // Saturate rather than wrap a runaway loop
        if (next_power > ACC_W'(16'sh7FFF)) begin
            next_power = ACC_W'(16'sh7FFF);
        end else if (next_power < ACC_W'(-16'sh7FFF)) begin
            next_power = ACC_W'(-16'sh7FFF);
        end
    end

    // Non-primary needs both a mismatch and a trusted uplink
    assign decision = !((link.beam_id != own_id_in) &&
                        (quality_in >= quality_thr_in)); // R12

    // Power loop, one step per frame
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power           <= dpc_pkg::DL_POWER_RST;
            decoded_cmd_out <= dpc_pkg::DPC_UP_SMALL;
        end else if (link.frame) begin
            power           <= next_power[dpc_pkg::PWR_W-1:0]; // R5
            decoded_cmd_out <= link.power_cmd;
        end
    end

    // Decisions wait offset+1 frames so all beams switch together
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_line <= '0;
            valid_line <= '0;
            primary    <= 1'b1;
        end else if (link.frame) begin
            state_line <= {state_line[MAX_OFS-1:0], decision};
            valid_line <= {valid_line[MAX_OFS-1:0], link.id_valid};
            if (valid_line[frame_offset_in]) begin
                primary <= state_line[frame_offset_in]; // R13
            end
        end
    end

    // Registered outputs; control and data share every step
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_power_out <= dpc_pkg::DL_POWER_RST;
            data_power_out <= dpc_pkg::DL_POWER_RST;
            primary_out    <= 1'b1;
            link.dl_power  <= dpc_pkg::DL_POWER_RST;
            link.data_on   <= 1'b1;
        end else begin
            ctrl_power_out <= power; // R1
            data_power_out <= power + data_offset_in; // R1
            primary_out    <= primary;
            link.dl_power  <= power;
            link.data_on   <= !diversity_in || primary; // R7
        end
    end
endmodule : dpc_beam_end

// ---- core/dpc_link_if.sv ----
// Frame-rate link between the mobile terminal and one active beam
interface dpc_link_if;
    logic                        frame;
    logic [1:0]                  power_cmd;
    logic [dpc_pkg::ID_W-1:0]    beam_id;
    logic                        id_valid;
    logic [dpc_pkg::PWR_W-1:0]   ul_ctrl_power;
    logic                        data_on;
    logic [dpc_pkg::PWR_W-1:0]   dl_power;

    modport mobile (
        output frame, power_cmd, beam_id, id_valid, ul_ctrl_power,
        input  data_on, dl_power
    );
    modport beam (
        input  frame, power_cmd, beam_id, id_valid, ul_ctrl_power,
        output data_on, dl_power
    );
endinterface : dpc_link_if

// ---- core/dpc_mobile_end.sv ----
// Summary of operation
// R1 - Network steps control and data power equally
// R2 - Two-bit command: 00/01 above, 10/11 below target
// R3 - Soft handover without diversity: combine all beams
// R4 - Optional predicted change added before command choice
// R5 - Network updates power once per frame
// R6 - Codes map to -L, -S, +S, +L steps
// R7 - Only primary beam transmits the data channel; the beam end keeps data_on high on every beam while diversity_in is low
// R8 - Primary beam identifier sent in feedback field
// R9 - One 15-bit identifier per frame under diversity
// R10 - Under diversity, command uses primary beam only
// R11 - Highest pilot power beam becomes primary
// R12 - Non-primary only on mismatch and good quality
// R13 - New beam state applies at frame j+1+offset
// R14 - Uplink control power changes at frame start
// R15 - One fresh command per frame; target, threshold set
//
// Local design decisions: the APB interface to the registers and the register addresses.
module dpc_mobile_end #(
    parameter int NUM_BEAMS = dpc_pkg::NUM_BEAMS_DEF
) (
    // Clock and reset
    input  wire logic                         clock_in,
    input  wire logic                         rst_n_in,
    // APB slave
    input  wire logic                         psel_in,
    input  wire logic                         penable_in,
    input  wire logic                         pwrite_in,
    input  wire logic [dpc_pkg::APB_AW-1:0]   paddr_in,
    input  wire logic [dpc_pkg::DATA_W-1:0]   pwdata_in,
    output logic                              pready_out,
    output logic [dpc_pkg::DATA_W-1:0]        prdata_out,
    output logic                              pslverr_out,
    // Receiver measurements, one frame tick per uplink frame
    input  wire logic                         frame_tick_in,
    input  wire logic [NUM_BEAMS-1:0]         beam_active_in,
    input  wire logic [NUM_BEAMS*dpc_pkg::SIR_W-1:0] sir_est_in,
    input  wire logic [NUM_BEAMS*dpc_pkg::SIR_W-1:0] pilot_pwr_in,
    input  wire logic signed [dpc_pkg::SIR_W-1:0]    pred_delta_in,
    // Link to the active beams
    dpc_link_if.mobile                        link
);
    localparam int IDX_W = (NUM_BEAMS > 1) ? $clog2(NUM_BEAMS) : 1;
    localparam int EST_W = dpc_pkg::SIR_W + 4;

    generate
        if (NUM_BEAMS < 1 || NUM_BEAMS > 8) begin : g_bad_beams
            $error("NUM_BEAMS must lie between 1 and 8");
        end
    endgenerate

    // Software-visible configuration
    logic                         diversity_en;
    logic                         predict_en;
    logic                         soft_handover;
    logic [dpc_pkg::SIR_W-1:0]    sir_target;
    logic [dpc_pkg::SIR_W-1:0]    threshold;
    logic [dpc_pkg::PWR_W-1:0]    ul_power_pending;
    logic [dpc_pkg::ID_W-1:0]     beam_id [NUM_BEAMS];
    logic [IDX_W-1:0]             primary_idx;

    // Frame computation
    logic [IDX_W-1:0]             next_primary_idx;
    logic signed [EST_W-1:0]      next_est;
    logic [1:0]                   next_cmd;

    // APB decode
    logic                         setup_phase;
    logic                         write_done;
    logic                         addr_hit;
    logic [dpc_pkg::DATA_W-1:0]   read_word;

    // Command encoder: sign picks direction, magnitude picks step size
    function automatic logic [1:0] encode_cmd(
        input logic signed [EST_W-1:0] diff,
        input logic [dpc_pkg::SIR_W-1:0] thr
    );
        logic signed [EST_W-1:0] mag;
        logic                    far;
        mag = (diff < 0) ? -diff : diff;
        far = (mag > $signed({{(EST_W-dpc_pkg::SIR_W){1'b0}}, thr}));
        if (diff > 0) begin
            encode_cmd = far ? dpc_pkg::DPC_DOWN_LARGE
                             : dpc_pkg::DPC_DOWN_SMALL; // R2
        end else begin
            encode_cmd = far ? dpc_pkg::DPC_UP_LARGE
                             : dpc_pkg::DPC_UP_SMALL; // R2
        end
    endfunction : encode_cmd

    // Strongest active pilot becomes the primary candidate
    always_comb begin
        logic [dpc_pkg::SIR_W-1:0] best;
        best = '0;
        next_primary_idx = primary_idx;
        for (int i = 0; i < NUM_BEAMS; i++) begin
            if (beam_active_in[i] &&
                pilot_pwr_in[i*dpc_pkg::SIR_W +: dpc_pkg::SIR_W] >= best)
            begin
                best = pilot_pwr_in[i*dpc_pkg::SIR_W +: dpc_pkg::SIR_W];
                next_primary_idx = IDX_W'(i); // R11
            end
        end
    end

    // Ratio estimate; inputs are linear so combining is a plain sum
    always_comb begin
        logic [EST_W-1:0] sum;
        sum = '0;
        if (diversity_en) begin
            sum = EST_W'(sir_est_in[next_primary_idx*dpc_pkg::SIR_W
                                    +: dpc_pkg::SIR_W]); // R10
        end else if (soft_handover) begin
            for (int i = 0; i < NUM_BEAMS; i++) begin
                if (beam_active_in[i]) begin
                    sum = sum + EST_W'(sir_est_in[i*dpc_pkg::SIR_W
                                                  +: dpc_pkg::SIR_W]); // R3
                end
            end
        end else begin
            sum = EST_W'(sir_est_in[dpc_pkg::SIR_W-1:0]);
        end
        next_est = $signed(sum);
        if (predict_en) begin
            next_est = next_est + EST_W'(pred_delta_in); // R4
        end
        next_cmd = encode_cmd(next_est -
                              $signed(EST_W'(sir_target)), threshold);
    end

    // Link outputs change together at the frame boundary
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link.frame         <= 1'b0;
            link.power_cmd     <= dpc_pkg::DPC_UP_SMALL;
            link.beam_id       <= '0;
            link.id_valid      <= 1'b0;
            link.ul_ctrl_power <= dpc_pkg::UL_POWER_RST;
            primary_idx        <= '0;
        end else begin
            link.frame <= frame_tick_in;
            if (frame_tick_in) begin
                link.power_cmd     <= next_cmd; // R15
                link.ul_ctrl_power <= ul_power_pending; // R14
                primary_idx        <= next_primary_idx; // R11
                link.beam_id       <= beam_id[next_primary_idx]; // R8
                link.id_valid      <= diversity_en; // R9
            end
        end
    end

    // APB handshake: answer in the first access cycle
    assign setup_phase = psel_in && !penable_in;
    assign write_done  = psel_in && penable_in && pready_out && pwrite_in;

    // Address decode and read mux
    always_comb begin
        logic [dpc_pkg::APB_AW-1:0] rel;
        rel       = paddr_in - dpc_pkg::REG_BEAM_ID;
        addr_hit  = 1'b1;
        read_word = '0;
        case (paddr_in)
            dpc_pkg::REG_CTRL: begin
                read_word[dpc_pkg::CTRL_DIV_BIT]  = diversity_en;
                read_word[dpc_pkg::CTRL_PRED_BIT] = predict_en;
                read_word[dpc_pkg::CTRL_SHO_BIT]  = soft_handover;
            end
            dpc_pkg::REG_SIR_TARGET: begin
                read_word[dpc_pkg::SIR_W-1:0] = sir_target;
            end
            dpc_pkg::REG_THRESH: begin
                read_word[dpc_pkg::SIR_W-1:0] = threshold;
            end
            dpc_pkg::REG_UL_POWER: begin
                read_word[dpc_pkg::PWR_W-1:0] = ul_power_pending;
            end
            dpc_pkg::REG_STATUS: begin
                read_word[dpc_pkg::STAT_CMD_LSB +: 2] = link.power_cmd;
                read_word[dpc_pkg::STAT_DATA_BIT]     = link.data_on;
                read_word[dpc_pkg::STAT_PRIM_LSB +: IDX_W] = primary_idx;
                read_word[dpc_pkg::STAT_ID_LSB +: dpc_pkg::PWR_W] =
                    link.dl_power;
            end
            default: begin
                addr_hit = 1'b0;
                if (paddr_in >= dpc_pkg::REG_BEAM_ID &&
                    rel[1:0] == 2'b00 && (rel >> 2) < NUM_BEAMS) begin
                    addr_hit = 1'b1;
                    read_word[dpc_pkg::ID_W-1:0] =
                        beam_id[rel[IDX_W+1:2]];
                end
            end
        endcase
    end

    // APB response registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= setup_phase;
            pslverr_out <= setup_phase && !addr_hit;
            prdata_out  <= (setup_phase && !pwrite_in) ? read_word : '0;
        end
    end

    // Configuration writes; unmapped writes change nothing
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            diversity_en     <= 1'b0;
            predict_en       <= 1'b0;
            soft_handover    <= 1'b0;
            sir_target       <= dpc_pkg::SIR_TARGET_RST;
            threshold        <= dpc_pkg::THRESH_RST;
            ul_power_pending <= dpc_pkg::UL_POWER_RST;
        end else if (write_done) begin
            case (paddr_in)
                dpc_pkg::REG_CTRL: begin
                    diversity_en  <= pwdata_in[dpc_pkg::CTRL_DIV_BIT];
                    predict_en    <= pwdata_in[dpc_pkg::CTRL_PRED_BIT];
                    soft_handover <= pwdata_in[dpc_pkg::CTRL_SHO_BIT];
                end
                dpc_pkg::REG_SIR_TARGET: begin
                    sir_target <= pwdata_in[dpc_pkg::SIR_W-1:0]; // R15
                end
                dpc_pkg::REG_THRESH: begin
                    threshold <= pwdata_in[dpc_pkg::SIR_W-1:0]; // R15
                end
                dpc_pkg::REG_UL_POWER: begin
                    ul_power_pending <= pwdata_in[dpc_pkg::PWR_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Beam identifier table, one word per beam
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NUM_BEAMS; i++) begin
                beam_id[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_BEAMS; i++) begin
                if (write_done &&
                    paddr_in == dpc_pkg::REG_BEAM_ID + 8'(4 * i)) begin
                    beam_id[i] <= pwdata_in[dpc_pkg::ID_W-1:0];
                end
            end
        end
    end
endmodule : dpc_mobile_end

// ---- core/dpc_pkg.sv ----
package dpc_pkg;
    // Widths of the link and the APB port, and parameter defaults of the two ends
    localparam int SIR_W         = 16;
    localparam int ID_W          = 15;
    localparam int PWR_W         = 16;
    localparam int APB_AW        = 8;
    localparam int DATA_W        = 32;
    localparam int NUM_BEAMS_DEF = 4;
    localparam int MAX_OFS_DEF   = 7;

    // Register offsets of the mobile end
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_SIR_TARGET = 8'h04;
    localparam logic [7:0] REG_THRESH     = 8'h08;
    localparam logic [7:0] REG_UL_POWER   = 8'h0C;
    localparam logic [7:0] REG_STATUS     = 8'h10;
    localparam logic [7:0] REG_BEAM_ID    = 8'h20;

    // Control and status field positions
    localparam int CTRL_DIV_BIT  = 0;
    localparam int CTRL_PRED_BIT = 1;
    localparam int CTRL_SHO_BIT  = 2;
    localparam int STAT_CMD_LSB  = 0;
    localparam int STAT_DATA_BIT = 2;
    localparam int STAT_PRIM_LSB = 4;
    localparam int STAT_ID_LSB   = 16;

    // Reset values
    localparam logic [SIR_W-1:0] SIR_TARGET_RST = 16'h0100;
    localparam logic [SIR_W-1:0] THRESH_RST     = 16'h0040;
    localparam logic [PWR_W-1:0] UL_POWER_RST   = 16'h0000;
    localparam logic [PWR_W-1:0] DL_POWER_RST   = 16'h0000;

    // Two-bit power command codes
    typedef enum logic [1:0] {
        DPC_DOWN_LARGE = 2'b00,
        DPC_DOWN_SMALL = 2'b01,
        DPC_UP_SMALL   = 2'b10,
        DPC_UP_LARGE   = 2'b11
    } dpc_cmd_e;
endpackage : dpc_pkg

// ---- test/downlink_power_ctrl_beam_select_test.sv ----
module downlink_power_ctrl_beam_select_test;
    timeunit 1ns;
    timeprecision 1ps;

    // Stimulus and observed signals
    logic                clock_in = 1'b0;
    logic                rst_n_in = 1'b0;
    logic                psel     = 1'b0;
    logic                penable  = 1'b0;
    logic                pwrite   = 1'b0;
    logic [7:0]          paddr    = 8'h00;
    logic [31:0]         pwdata   = 32'h0;
    logic                frame_tick = 1'b0;
    logic [3:0]          active   = 4'h1;
    logic [63:0]         sir      = 64'h0;
    logic [63:0]         pilot    = 64'h0;
    logic signed [15:0]  pred     = 16'h0000;
    logic [15:0]         quality  = 16'h0050;
    logic [15:0]         pw       = 16'h0000;
    logic [14:0]         own_id   = 15'h1232;
    logic signed [15:0]  bal      = 16'sh0000;
    logic signed [15:0]  doff     = 16'sh0010;
    logic [15:0]         qthr     = 16'h0040;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
    logic [1:0]          dcmd;
    logic signed [15:0]  ctrl_pw;
    logic signed [15:0]  data_pw;
    logic                primary;
    int                  err_count = 0;
    int                  tests_run = 0;
    int                  cycles    = 0;
    logic [15:0]         stp [4]   = '{16'hFFFC, 16'hFFFF, 16'h0001, 16'h0004};

    dpc_link_if link ();

    dpc_mobile_end #(.NUM_BEAMS(4)) dpc_mobile_end_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
        .pslverr_out(pslverr), .frame_tick_in(frame_tick),
        .beam_active_in(active), .sir_est_in(sir), .pilot_pwr_in(pilot),
        .pred_delta_in(pred), .link(link.mobile));

    dpc_beam_end #(.MAX_OFS(7)) dpc_beam_end_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .own_id_in(own_id),
        .diversity_in(1'b1), .frame_offset_in(3'h2),
        .step_small_in(16'h0001), .step_large_in(16'h0004),
        .balance_in(bal), .data_offset_in(doff),
        .quality_in(quality), .quality_thr_in(qthr),
        .decoded_cmd_out(dcmd), .ctrl_power_out(ctrl_pw),
        .data_power_out(data_pw), .primary_out(primary),
        .link(link.beam));

    dpc_link_chk dpc_link_chk_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .frame(link.frame),
        .power_cmd(link.power_cmd), .beam_id(link.beam_id),
        .id_valid(link.id_valid), .ul_ctrl_power(link.ul_ctrl_power),
        .data_on(link.data_on), .dl_power(link.dl_power));

    // 100 MHz clock and a cycle ceiling against hangs
    always #5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, input logic [31:0] exp,
                       input logic exp_err);
        @(posedge clock_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock_in);
        penable <= 1'b1;
        // Only the bench ceiling ends a wait that never answers
        do begin
            @(posedge clock_in);
        end while (pready !== 1'b1);
        if (!wr) chk(prdata, exp);
        chk({31'h0, pslverr}, {31'h0, exp_err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One frame, then the command on both ends and every downlink power figure are judged
    task automatic tick(input logic [1:0] cmd);
        @(posedge clock_in);
        frame_tick <= 1'b1;
        @(posedge clock_in);
        frame_tick <= 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
        pw = pw + stp[cmd] + bal;
        chk({30'h0, link.power_cmd}, {30'h0, cmd});
        chk({30'h0, dcmd}, {30'h0, cmd});
        chk({16'h0, link.dl_power}, {16'h0, pw});
        chk({16'h0, ctrl_pw}, {16'h0, pw});
        chk({16'h0, data_pw}, {16'h0, pw + doff});
    endtask : tick

    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h04, 32'h0, 32'h0000_0100, 1'b0);
        apb(1'b0, 8'h08, 32'h0, 32'h0000_0040, 1'b0);
        apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF, 32'h0, 1'b1);
        apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
        $display("t_regs done");
    endtask : t_regs

    // Each code, with the threshold boundary hit from both sides
    task automatic t_cmd();
        logic [15:0] est [5] = '{16'h0200, 16'h0140, 16'h0100, 16'h00C0,
                                 16'h0080};
        logic [1:0]  code [5] = '{2'b00, 2'b01, 2'b10, 2'b10, 2'b11};
        apb(1'b1, 8'h0C, 32'h0000_0033, 32'h0, 1'b0);
        chk({16'h0, link.ul_ctrl_power}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            @(posedge clock_in);
            sir[15:0] <= est[i];
            tick(code[i]);
            chk({16'h0, link.ul_ctrl_power}, 32'h0000_0033);
            chk({31'h0, link.id_valid}, 32'h0);
        end
        $display("t_cmd done");
    endtask : t_cmd

    task automatic t_modes();
        apb(1'b1, 8'h00, 32'h0000_0002, 32'h0, 1'b0);
        @(posedge clock_in);
        sir[15:0] <= 16'h0100;
        pred <= 16'sh0100;
        tick(2'b00);
        apb(1'b1, 8'h00, 32'h0000_0004, 32'h0, 1'b0);
        @(posedge clock_in);
        pred <= 16'sh0000;
        active <= 4'h3;
        sir[31:0] <= {16'h0080, 16'h0080};
        tick(2'b10);
        apb(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
        // Balancing term joins the step for this one frame
        bal <= 16'sh0002;
        tick(2'b11);
        bal <= 16'sh0000;
        $display("t_modes done");
    endtask : t_modes

    // Primary choice, id per frame, and the delayed beam state change
    task automatic t_div();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h20 + 8'(4 * i), 32'h1230 + i, 32'h0, 1'b0);
        end
        @(posedge clock_in);
        active <= 4'hF;
        sir <= {16'h0010, 16'h0120, 16'h0120, 16'h0010};
        pilot <= {16'h0100, 16'h0300, 16'h0200, 16'h0100};
        apb(1'b1, 8'h00, 32'h0000_0005, 32'h0, 1'b0);
        tick(2'b01);
        chk({17'h0, link.beam_id}, 32'h0000_1232);
        chk({31'h0, link.id_valid}, 32'h1);
        apb(1'b0, 8'h10, 32'h0, {pw, 9'h0, 3'h2, 1'b0, 1'b1, 2'b01}, 1'b0);
        apb(1'b0, 8'h24, 32'h0, 32'h0000_1231, 1'b0);
        @(posedge clock_in);
        quality <= 16'h0030;
        pilot <= {16'h0100, 16'h0200, 16'h0400, 16'h0100};
        repeat (4) tick(2'b01);
        chk({31'h0, link.data_on}, 32'h1);
        chk({17'h0, link.beam_id}, 32'h0000_1231);
        @(posedge clock_in);
        quality <= 16'h0050;
        for (int k = 0; k < 4; k++) begin
            tick(2'b01);
            chk({31'h0, link.data_on}, (k < 3) ? 32'h1 : 32'h0);
        end
        chk({31'h0, primary}, 32'h0);
        @(posedge clock_in);
        pilot <= {16'h0100, 16'h0300, 16'h0200, 16'h0100};
        repeat (4) tick(2'b01);
        chk({31'h0, link.data_on}, 32'h1);
        $display("t_div done");
    endtask : t_div

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // Reset for five cycles, then the scenarios in turn
    initial begin
        repeat (5) @(posedge clock_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_cmd();
        t_modes();
        t_div();
        summarize();
    end
endmodule : downlink_power_ctrl_beam_select_test

// ---- test/dpc_link_chk.sv ----
// Watches the frame link between the mobile end and one beam end
module dpc_link_chk (
    input wire logic                      clock_in,
    input wire logic                      rst_n_in,
    input wire logic                      frame,
    input wire logic [1:0]                power_cmd,
    input wire logic [dpc_pkg::ID_W-1:0]  beam_id,
    input wire logic                      id_valid,
    input wire logic [dpc_pkg::PWR_W-1:0] ul_ctrl_power,
    input wire logic                      data_on,
    input wire logic [dpc_pkg::PWR_W-1:0] dl_power
);
    timeunit 1ns;
    timeprecision 1ps;

    // One clock domain, so one default clock and reset
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    // Mobile outputs only move with a frame pulse
    cmd_hold_a: assert property (!frame |-> $stable(power_cmd))
        else $error("power command moved between frames");
    id_hold_a: assert property (!frame |-> $stable(beam_id))
        else $error("beam id moved between frames");
    idv_hold_a: assert property (!frame |-> $stable(id_valid))
        else $error("id valid moved between frames");
    idv_rise_a: assert property ($rose(id_valid) |-> frame)
        else $error("id valid rose without a frame");
    ulpow_hold_a: assert property (!frame |-> $stable(ul_ctrl_power))
        else $error("uplink control power moved inside a frame");

    // Beam outputs settle one cycle after the frame step itself
    dl_update_a: assert property ($changed(dl_power) |-> $past(frame, 2))
        else $error("downlink power changed without a frame");
    data_upd_a: assert property ($changed(data_on) |-> $past(frame, 2))
        else $error("data enable changed off the frame boundary");
    dl_sat_a: assert property (dl_power != 16'h8000)
        else $error("downlink power passed the saturation limit");

    // Main scenarios reached
    cover property (frame && id_valid);
    cover property ($fell(data_on));
    cover property (frame && power_cmd == 2'b00);
    cover property ($changed(dl_power));
endmodule : dpc_link_chk
